//--- hw/srp_slave.sv
// Serial slave port giving a master access to registers and a FIFO port.
// Assumes the pins are asynchronous and slow against core_clk (>= 8x).
`default_nettype none
module srp_slave (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    output logic [6:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    output logic frame_active
);
    logic sel_s;
    logic sel_rise;
    logic sel_fall;
    logic sclk_s;
    logic sclk_rise;
    logic sclk_fall;
    logic sdi_s;
    logic [7:0] rx_byte;
    logic tx_bit;

    srp_sync u_sel (
        .clk(core_clk), .resetn(resetn), .ce(clk_en), .init_val(1'b1),
        .async_in(sel_n), .sync_out(sel_s), .rise(sel_rise), .fall(sel_fall)
    );
    srp_sync u_sclk (
        .clk(core_clk), .resetn(resetn), .ce(clk_en), .init_val(1'b0),
        .async_in(sclk), .sync_out(sclk_s), .rise(sclk_rise), .fall(sclk_fall)
    );
    srp_sync u_sdi (
        .clk(core_clk), .resetn(resetn), .ce(clk_en), .init_val(1'b0),
        .async_in(sdi), .sync_out(sdi_s), .rise(), .fall()
    );

    srp_pkg::srp_state_t state_q;
    logic [2:0] bit_q;
    logic write_q;
    logic fifo_q;
    logic first_q;
    logic [6:0] addr_q;
    logic [7:0] wdata_q;
    logic rd_q;
    logic wr_q;
    logic load_q;
    logic step_q;

    wire in_frame = (state_q != srp_pkg::SRP_IDLE) && !sel_s;
    // Rising clock edges only count inside a frame.
    wire take_bit = in_frame && sclk_rise; // R1 R7
    wire byte_done = take_bit && (bit_q == srp_pkg::LAST_BIT);

    srp_shift u_shift (
        .clk(core_clk), .resetn(resetn), .ce(clk_en), .clear(sel_fall),
        .sample(take_bit), .sdi(sdi_s), .load(load_q), .load_val(reg_rdata),
        .shift_out(in_frame && sclk_fall && (bit_q != 3'h0) && !load_q), .rx_byte(rx_byte),
        .sdo(tx_bit)
    );

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            state_q <= srp_pkg::SRP_IDLE;
        else if (clk_en)
        begin
            if (sel_rise || sel_s)
                state_q <= srp_pkg::SRP_IDLE; // R13
            else if (sel_fall)
                state_q <= srp_pkg::SRP_ADDR; // R9
            else if (byte_done && state_q == srp_pkg::SRP_ADDR)
                state_q <= srp_pkg::SRP_DATA; // R15
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            bit_q <= 3'h0;
        else if (clk_en)
        begin
            if (sel_fall)
                bit_q <= 3'h0; // R17
            else if (take_bit)
                bit_q <= bit_q + 3'h1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            write_q <= 1'b0;
            fifo_q <= 1'b0;
            first_q <= 1'b0;
            addr_q <= 7'h00;
        end
        else if (clk_en)
        begin
            if (byte_done && state_q == srp_pkg::SRP_ADDR)
            begin
                write_q <= rx_byte[srp_pkg::DIR_BIT]; // R11
                addr_q <= rx_byte[6:0];
                fifo_q <= (rx_byte[6:0] == srp_pkg::FIFO_ADDR); // R5
                first_q <= 1'b1;
            end
            else if (byte_done && state_q == srp_pkg::SRP_DATA)
                first_q <= 1'b0;
            else if (step_q && !fifo_q)
                addr_q <= addr_q + 7'h01; // R4
        end
    end

    // Write data commits only on a full byte; a short byte is dropped.
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            load_q <= 1'b0;
            step_q <= 1'b0;
            wdata_q <= 8'h00;
        end
        else if (clk_en)
        begin
            wr_q <= byte_done && state_q == srp_pkg::SRP_DATA && write_q; // R17
            if (byte_done && state_q == srp_pkg::SRP_DATA && write_q)
                wdata_q <= rx_byte;
            // The address steps in the write cycle, so the fetch that follows sees the next one.
            step_q <= byte_done && state_q == srp_pkg::SRP_DATA;
            rd_q <= (byte_done && state_q == srp_pkg::SRP_ADDR) || step_q; // R14 R16
            load_q <= rd_q;
        end
    end

    sequence s_write_end;
        clk_en && byte_done && state_q == srp_pkg::SRP_DATA && write_q;
    endsequence
    sequence s_step;
        clk_en && step_q;
    endsequence

    property p_oe_idle;
        @(posedge core_clk) disable iff (!resetn) sel_s |-> !sdo_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output enabled while deselected"); // R10

    property p_commit;
        @(posedge core_clk) disable iff (!resetn) s_write_end |=> reg_wr;
    endproperty
    a_commit: assert property (p_commit) else $error("full byte not committed"); // R17

    property p_wr_full;
        @(posedge core_clk) disable iff (!resetn)
            reg_wr |-> $past(byte_done && state_q == srp_pkg::SRP_DATA && write_q);
    endproperty
    a_wr_full: assert property (p_wr_full) else $error("write without a full byte"); // R17

    property p_fetch;
        @(posedge core_clk) disable iff (!resetn) s_step |=> reg_rd ##1 load_q;
    endproperty
    a_fetch: assert property (p_fetch) else $error("next byte not fetched"); // R16

    property p_fifo_hold;
        @(posedge core_clk) disable iff (!resetn) (clk_en && step_q && fifo_q) |=> $stable(addr_q);
    endproperty
    a_fifo_hold: assert property (p_fifo_hold) else $error("fifo address moved"); // R5

    property p_addr_inc;
        @(posedge core_clk) disable iff (!resetn)
            (clk_en && step_q && !fifo_q) |=> addr_q == $past(addr_q) + 7'h01;
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("address did not step"); // R4

    property p_sdo_hold;
        @(posedge core_clk) disable iff (!resetn) (clk_en && take_bit) |=> $stable(sdo);
    endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("output changed at rising edge"); // R8

    assign reg_addr = (byte_done && state_q == srp_pkg::SRP_ADDR) ? rx_byte[6:0] : addr_q;
    assign reg_rd = rd_q;
    assign reg_wr = wr_q;
    assign reg_wdata = wdata_q;
    assign frame_active = in_frame;
    assign sdo = tx_bit; // R8
    assign sdo_oe = in_frame; // R10 R2
endmodule
`default_nettype wire

//--- shared/srp_pkg.sv
// Constants and types shared by the serial register port.
// Assumes a single core clock domain; serial pins are synchronised inside.
// Notes on behaviour
// (R1) Mode zero: clock idles low, sample leading.
// (R2) Slave only; never drives clock or select.
// (R3) Single access: address, one byte, deselect.
// (R4) Non-FIFO address increments after each byte.
// (R5) FIFO address held for whole frame.
// (R6) Master changes input data on falling edge.
// (R7) Input bit captured on rising edge.
// (R8) Output bit updated on falling edge.
// (R9) Select falling starts frame with address.
// (R10) Output released while select high.
// (R11) First byte: write flag, seven-bit address.
// (R12) Data bytes shifted most significant first.
// (R13) Select rising ends frame; restart address.
// (R14) Write returns register's old contents.
// (R15) Burst keeps select low, no address resend.
// (R16) Read drives register content next byte.
// (R17) Commit write only after eight bits.
`default_nettype none
package srp_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [6:0] FIFO_ADDR = 7'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int DIR_BIT = 7;
    typedef enum logic [1:0] {SRP_IDLE, SRP_ADDR, SRP_DATA} srp_state_t;
endpackage
`default_nettype wire

//--- hw/srp_sync.sv
// Two-stage synchroniser with edge detection on the second stage output.
// Assumes the input is asynchronous to clk.
`default_nettype none
module srp_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic init_val,
    input wire logic async_in,
    output logic sync_out,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            meta_q <= init_val;
            sync_q <= init_val;
            prev_q <= init_val;
        end
        else if (ce)
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Init value masks the output and edges only for the first enabled cycle after reset.
    logic live_q;
    always_ff @(posedge clk)
    begin
        if (!resetn)
            live_q <= 1'b0;
        else if (ce)
            live_q <= 1'b1;
    end

    assign sync_out = live_q ? sync_q : init_val;
    assign rise = live_q && ce && sync_q && !prev_q;
    assign fall = live_q && ce && !sync_q && prev_q;
endmodule
`default_nettype wire

//--- hw/srp_shift.sv
// Eight-bit shifter: collects input bits and presents output bits, MSB first.
// Assumes strobes are one-cycle pulses from the synchronised serial clock.
`default_nettype none
module srp_shift (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic clear,
    input wire logic sample,
    input wire logic sdi,
    input wire logic load,
    input wire logic [7:0] load_val,
    input wire logic shift_out,
    output logic [7:0] rx_byte,
    output logic sdo
);
    logic [7:0] rx_q;
    logic [7:0] tx_q;

    always_ff @(posedge clk)
    begin
        if (!resetn)
            rx_q <= 8'h00;
        else if (ce)
        begin
            if (clear)
                rx_q <= 8'h00;
            else if (sample)
                rx_q <= {rx_q[6:0], sdi}; // R12
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            tx_q <= 8'h00;
        else if (ce)
        begin
            if (load)
                tx_q <= load_val;
            else if (shift_out)
                tx_q <= {tx_q[6:0], 1'b0}; // R12
        end
    end

    assign rx_byte = {rx_q[6:0], sdi};
    assign sdo = tx_q[7];
endmodule
`default_nettype wire

//--- tb/srp_master.sv
// Mode-zero serial master model that drives the slave's select, clock and data pins.
// Assumes clk is the bench core clock; the serial clock period is eight core cycles.
`default_nettype none
module srp_master (
    input wire logic clk,
    output logic sel_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    task automatic start();
        @(posedge clk);
        sel_n <= 1'b0;
        half();
    endtask
    // Sends the top n bits of tx and collects the bits the slave returns.
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            sdi <= tx[i];
            half();
            sclk <= 1'b1;
            rx[i] = sdo;
            half();
            sclk <= 1'b0;
        end
    endtask
    // A released data line shows the inverse of its last value.
    task automatic stop();
        half();
        sel_n <= 1'b1;
        sdi <= ~sdi;
        half();
    endtask
endmodule
`default_nettype wire

//--- tb/tb_srp_slave.sv
// Self-checking bench for the serial register port against a register array model.
// Assumes the master model in srp_master.sv and the design in srp_slave.sv.
`default_nettype none
module tb_srp_slave;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, resetn, sel_n, sclk, sdi, sdo, sdo_oe, reg_rd, reg_wr, frame_active;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata = 8'h00;
    logic [7:0] regs [128];
    logic [7:0] mdl [128];
    logic [31:0] lf;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    srp_slave u_srp_slave (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
        .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .frame_active(frame_active));
    srp_master u_srp_master (.clk(core_clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
        .sdo(sdo));
    always @(posedge core_clk)
    begin
        if (reg_rd)
            reg_rdata <= regs[reg_addr];
        if (reg_wr)
            regs[reg_addr] <= reg_wdata;
    end
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // The last byte carries only last bits, so a short value aborts it.
    task automatic frame(input logic wr, input logic [6:0] a, input int n, input int last);
        logic [7:0] rx;
        logic [7:0] tx;
        u_srp_master.start();
        u_srp_master.xfer({wr, a}, 8, rx);
        for (int k = 0; k < n; k++)
        begin
            lf = nxt(lf);
            tx = lf[7:0];
            u_srp_master.xfer(tx, (k == n - 1) ? last : 8, rx);
            if (k < n - 1 || last == 8)
            begin
                if (!(wr && a == 7'h00 && k > 0))
                    check("read byte", rx, mdl[a]);
                if (wr)
                    mdl[a] = tx;
                a = (a == 7'h00) ? a : a + 7'h01;
            end
        end
        u_srp_master.stop();
        check("output enable", {7'h00, sdo_oe}, 8'h00);
        check("frame active", {7'h00, frame_active}, 8'h00);
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    initial
    begin
        resetn = 1'b0;
        lf = 32'h0000_0A36;
        for (int i = 0; i < 128; i++)
        begin
            lf = nxt(lf);
            regs[i] = lf[7:0];
            mdl[i] = lf[7:0];
        end
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        frame(1'b1, 7'h05, 1, 8);
        frame(1'b0, 7'h05, 1, 8);
        frame(1'b1, 7'h70, 4, 8);
        frame(1'b0, 7'h6F, 5, 8);
        frame(1'b1, 7'h00, 3, 8);
        frame(1'b0, 7'h00, 3, 8);
        frame(1'b1, 7'h10, 1, 3);
        frame(1'b0, 7'h10, 1, 8);
        for (int j = 0; j < 6; j++)
        begin
            lf = nxt(lf);
            frame(lf[8], {1'b0, lf[5:0]}, 1 + int'(lf[10:9]), 8);
        end
        for (int i = 0; i < 128; i++)
            check("register", regs[i], mdl[i]);
        report_and_stop();
    end
endmodule
`default_nettype wire
